// [clkpre_params.svh]
// Register map, reset values and timing counts of the clock prescaler
`ifndef CLKPRE_PARAMS_SVH
`define CLKPRE_PARAMS_SVH
`define PERIPH_SELECT_ADDR 8'h8F
`define RELOAD_ADDR        8'h97
`define TPS_SETTING_ADDR   8'hAE
`define RELOAD_RESET       8'hFF
`define RELOAD_BYPASS      8'hFF
`define SELECT_RESET       7'h00
`define TPS_RESET          4'h5
`define TPS_LSB            4
`define X2_BIT             0
`define SEL_LSB            1
`define UPDATE_MAX_OSC     1024
`define PRESCALER_USERS    7'h37
`endif

// [clkpre_pkg.sv]
// Types shared by the clock prescaler modules
package clkpre_pkg;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       we;
    logic       re;
  } reg_req_t;

  // Bit order matches the select register, bit 7 down to bit 1
  typedef struct packed {
    logic twi;
    logic wd;
    logic programmable_counter_array;
    logic si;
    logic t2;
    logic t1;
    logic t0;
  } periph_ticks_t;

  typedef struct packed {
    logic       half;
    logic [7:0] cnt;
    logic       lvl;
    logic       tick;
    logic       ovf;
  } div_state_t;

  typedef struct packed {
    logic [3:0] cnt;
    logic       tick;
  } tps_state_t;

  typedef struct packed {
    logic [7:0] rdata;
    logic [7:0] reload;
    logic [6:0] sel;
    logic       x2;
    logic [3:0] timer_prescale_count;
    logic [6:0] half;
    logic [6:0] ptick;
  } main_state_t;
endpackage

// [clock_prescaler.sv]
// System clock prescaler, timer prescaler and peripheral clock selection
//
// Function
// - System prescaler is an 8-bit up counter reloading at each FF to 00 overflow.
// - Reload value FF bypasses the system prescaler, no division.
// - Each overflow toggles the system clock; a period spans two overflows.
// - System rate is osc times 2^X2 over 4(255-reload), or over 2 at 255.
// - Ratios are even, 4 to 1020 single speed, 2 to 510 double speed.
// - Divided system clock drives the CPU and all peripherals together.
// - Reload may be rewritten anytime; counter takes it at next overflow, while FF bypasses at once.
// - New system rate applies within 1024 oscillator periods of the write.
// - Reset sets the reload register to all ones, disabling division.
// - Timer prescaler is a 4-bit down counter reloading at zero, ratio 1 to 16.
// - Timer prescale field resets to 5, one timer step per six cycles.
// - One shared timer prescaler serves timers, counter array and watchdog.
// - Compatibility mode always prescales timers, counter array and watchdog; fast mode only per selection bit.
// - Base peripheral clock equals the CPU clock, double speed and divider included.
// - Compatibility: prescaled peripheral rate is CPU over 2^bit times prescale+1.
// - Compatibility: non-prescaled peripherals pick CPU clock or half of it.
// - Fast mode: bit set gives CPU over prescale+1, clear bypasses prescaler.
// - Double speed clear halves the oscillator, set passes it undivided.
`timescale 1ns/100ps
`include "clkpre_params.svh"
module clock_prescaler #(
  parameter logic [6:0] USER_MASK = `PRESCALER_USERS
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     reset_i,
  input  wire clkpre_pkg::reg_req_t     reg_req_i,
  output logic [7:0]                    reg_rdata_o,
  input  wire logic                     fast_mode_i,
  input  wire logic                     x2_default_i,
  output logic                          cpu_tick_o,
  output logic                          sys_level_o,
  output logic                          x2_o,
  output clkpre_pkg::periph_ticks_t     periph_ticks_o
);
  import clkpre_pkg::*;

  localparam int UPDATE_MAX = `UPDATE_MAX_OSC;

  main_state_t st_r;
  main_state_t st_nxt;
  logic        cpu_tick;
  logic        pre_tick;
  logic        ovf;
  logic        base;
  logic        use_pre;

  ////////////////////////////////////////////////////////////////////////////
  // Clock generation

  sysclk_divider u_div (
    .sys_clk_i   (sys_clk_i),
    .reset_i     (reset_i),
    .x2_i        (st_r.x2),
    .reload_i    (st_r.reload),
    .cpu_tick_o  (cpu_tick),
    .sys_level_o (sys_level_o),
    .ovf_o       (ovf)
  );

  // Fed by the divided CPU tick, so it scales with reload and X2
  timer_prescaler u_tps (
    .sys_clk_i  (sys_clk_i),
    .reset_i    (reset_i),
    .cpu_tick_i (cpu_tick),
    .tps_i      (st_r.timer_prescale_count),
    .pre_tick_o (pre_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Registers and peripheral ticks

  always_comb begin
    st_nxt = st_r;
    base = 1'b0;
    use_pre = 1'b0;
    st_nxt.rdata = 8'h00;
    if (reg_req_i.we) begin
      if (reg_req_i.addr == `PERIPH_SELECT_ADDR) begin
        st_nxt.sel = reg_req_i.wdata[7:`SEL_LSB];
        st_nxt.x2 = reg_req_i.wdata[`X2_BIT];
      end else if (reg_req_i.addr == `RELOAD_ADDR) begin
        // No stall: the divider picks it up at its next overflow, or bypasses at once if FF
        st_nxt.reload = reg_req_i.wdata;
      end else if (reg_req_i.addr == `TPS_SETTING_ADDR) begin
        st_nxt.timer_prescale_count = reg_req_i.wdata[7:`TPS_LSB];
      end
    end
    if (reg_req_i.re) begin
      if (reg_req_i.addr == `PERIPH_SELECT_ADDR) begin
        st_nxt.rdata = {st_r.sel, st_r.x2};
      end else if (reg_req_i.addr == `RELOAD_ADDR) begin
        st_nxt.rdata = st_r.reload;
      end else if (reg_req_i.addr == `TPS_SETTING_ADDR) begin
        st_nxt.rdata = {st_r.timer_prescale_count, 4'h0};
      end
    end
    for (int i = 0; i < 7; i++) begin
      if (fast_mode_i) begin
        use_pre = st_r.sel[i];
      end else begin
        use_pre = USER_MASK[i];
      end
      base = use_pre ? pre_tick : cpu_tick;
      st_nxt.ptick[i] = base;
      // Extra halving in compatibility mode when the bit is set
      if (!fast_mode_i && st_r.sel[i]) begin
        if (base) begin
          st_nxt.half[i] = ~st_r.half[i];
        end
        st_nxt.ptick[i] = base & st_r.half[i];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.reload <= `RELOAD_RESET;
      st_r.timer_prescale_count <= `TPS_RESET;
      st_r.sel <= `SELECT_RESET;
      st_r.x2 <= x2_default_i;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign reg_rdata_o = st_r.rdata;
  assign cpu_tick_o = cpu_tick;
  assign x2_o = st_r.x2;
  assign periph_ticks_o = st_r.ptick;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  sequence s_reload_write;
    reg_req_i.we && reg_req_i.addr == `RELOAD_ADDR && reg_req_i.wdata != 8'hFF;
  endsequence

  a_reset_bypass: assert property (@(posedge sys_clk_i)
    reset_i |=> st_r.reload == 8'hFF)
    else $error("reload register not all ones after reset");
  a_tps_reset: assert property (@(posedge sys_clk_i)
    reset_i |=> st_r.timer_prescale_count == 4'h5)
    else $error("timer prescale field not 5 after reset");
  a_reload_latency: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_reload_write ##1 !reg_req_i.we [*8] |-> ##[1:UPDATE_MAX] ovf)
    else $error("new reload not in effect within 1024 cycles");
  a_read_select: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_req_i.re && reg_req_i.addr == `PERIPH_SELECT_ADDR
    |=> reg_rdata_o == {$past(st_r.sel), $past(st_r.x2)})
    else $error("select register read data wrong");
  a_fast_bypass: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fast_mode_i && !st_r.sel[0] |=> periph_ticks_o.t0 == $past(cpu_tick))
    else $error("fast mode clear bit must follow the CPU tick");
  a_compat_prescale: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !fast_mode_i && !st_r.sel[0] |=> periph_ticks_o.t0 == $past(pre_tick))
    else $error("compatibility mode must use the timer prescaler");
  a_compat_half: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !fast_mode_i && st_r.sel[0] && pre_tick && !st_r.half[0] |=> !periph_ticks_o.t0)
    else $error("compatibility halving let a tick through");

  ////////////////////////////////////////////////////////////////////////////
  // Register access checks

  sequence s_write(logic [7:0] a);
    reg_req_i.we && reg_req_i.addr == a;
  endsequence

  sequence s_read(logic [7:0] a);
    reg_req_i.re && reg_req_i.addr == a;
  endsequence

  a_write_select: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_write(`PERIPH_SELECT_ADDR)
    |=> st_r.sel == $past(reg_req_i.wdata[7:1]) && st_r.x2 == $past(reg_req_i.wdata[0]))
    else $error("select register write not taken");

  a_write_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_write(`RELOAD_ADDR)
    |=> st_r.reload == $past(reg_req_i.wdata))
    else $error("reload register write not taken");

  a_write_tps: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_write(`TPS_SETTING_ADDR)
    |=> st_r.timer_prescale_count == $past(reg_req_i.wdata[7:4]))
    else $error("prescale field write not taken");

  a_read_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_read(`RELOAD_ADDR)
    |=> reg_rdata_o == $past(st_r.reload))
    else $error("reload register read data wrong");

  a_read_tps: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    s_read(`TPS_SETTING_ADDR)
    |=> reg_rdata_o == {$past(st_r.timer_prescale_count), 4'h0})
    else $error("prescale register read data wrong");

  a_rdata_idle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !reg_req_i.re
    |=> reg_rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  a_write_quiet: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_req_i.we
    |=> reg_rdata_o == 8'h00)
    else $error("write produced read data");

  // Unmapped addresses must neither return data nor disturb any field
  a_unmapped_read: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_req_i.re && reg_req_i.addr != `PERIPH_SELECT_ADDR
      && reg_req_i.addr != `RELOAD_ADDR && reg_req_i.addr != `TPS_SETTING_ADDR
    |=> reg_rdata_o == 8'h00)
    else $error("unmapped read returned data");

  a_unmapped_write: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    reg_req_i.we && reg_req_i.addr != `PERIPH_SELECT_ADDR
      && reg_req_i.addr != `RELOAD_ADDR && reg_req_i.addr != `TPS_SETTING_ADDR
    |=> $stable(st_r.reload) && $stable(st_r.sel) && $stable(st_r.timer_prescale_count) && $stable(st_r.x2))
    else $error("unmapped write changed a register");

  ////////////////////////////////////////////////////////////////////////////
  // Reset checks

  a_x2_reset: assert property (@(posedge sys_clk_i)
    reset_i
    |=> x2_o == $past(x2_default_i))
    else $error("double speed bit not loaded from its default");

  a_outputs_reset: assert property (@(posedge sys_clk_i)
    reset_i
    |=> periph_ticks_o == 7'h00 && reg_rdata_o == 8'h00 && st_r.sel == 7'h00)
    else $error("ticks, read data or select not cleared by reset");

  ////////////////////////////////////////////////////////////////////////////
  // System clock checks

  // Outside bypass a CPU tick needs two overflows, hence even ratios
  a_cpu_tick_gap: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cpu_tick && st_r.reload != 8'hFF && $past(st_r.reload) != 8'hFF
    |=> !cpu_tick)
    else $error("CPU ticks in two cycles in a row while dividing");

  a_single_speed_gap: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cpu_tick && !st_r.x2 && $past(st_r.x2) == 1'b0
    |=> !cpu_tick)
    else $error("single speed let two CPU ticks through in a row");

  a_bypass_no_ovf: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    $past(st_r.reload) == 8'hFF
    |-> !ovf)
    else $error("counter overflowed while bypassed");

  a_ovf_tick: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ovf
    |-> cpu_tick == sys_level_o)
    else $error("CPU tick not on the rising overflow");

  a_pre_on_cpu: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    pre_tick
    |-> $past(cpu_tick))
    else $error("timer prescaler ticked without a CPU tick");

  a_tick_source: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    periph_ticks_o != 7'h00
    |-> $past(cpu_tick) || $past(cpu_tick, 2))
    else $error("peripheral tick not derived from the CPU tick");

  ////////////////////////////////////////////////////////////////////////////
  // Peripheral tick checks

  a_fast_all_direct: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    fast_mode_i && st_r.sel == 7'h00
    |=> periph_ticks_o == {7{$past(cpu_tick)}})
    else $error("fast mode with no select bits must skip the prescaler");

  a_compat_all_clear: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !fast_mode_i && st_r.sel == 7'h00
    |=> periph_ticks_o == (({7{$past(pre_tick)}} & USER_MASK)
                         | ({7{$past(cpu_tick)}} & ~USER_MASK)))
    else $error("compatibility mode sources wrong with no select bits");

  // One set of checks per peripheral bit
  for (genvar g = 0; g < 7; g++) begin : g_periph
    a_fast_direct: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      fast_mode_i && !st_r.sel[g]
      |=> periph_ticks_o[g] == $past(cpu_tick))
      else $error("fast mode clear bit did not bypass the prescaler");

    a_fast_prescaled: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      fast_mode_i && st_r.sel[g]
      |=> periph_ticks_o[g] == $past(pre_tick))
      else $error("fast mode set bit did not use the prescaler");

    a_compat_source: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !fast_mode_i && !st_r.sel[g]
      |=> periph_ticks_o[g] == (USER_MASK[g] ? $past(pre_tick) : $past(cpu_tick)))
      else $error("compatibility source wrong with bit clear");

    a_compat_gated: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !fast_mode_i && st_r.sel[g] && !st_r.half[g]
      |=> !periph_ticks_o[g])
      else $error("halving stage passed a tick in its closed phase");

    a_compat_open: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !fast_mode_i && st_r.sel[g] && st_r.half[g]
      |=> periph_ticks_o[g] == (USER_MASK[g] ? $past(pre_tick) : $past(cpu_tick)))
      else $error("halving stage blocked a tick in its open phase");

    a_half_step: assert property (@(posedge sys_clk_i) disable iff (reset_i)
      !fast_mode_i && st_r.sel[g] && (USER_MASK[g] ? pre_tick : cpu_tick)
      |=> st_r.half[g] != $past(st_r.half[g]))
      else $error("halving stage did not advance on its source tick");
  end
endmodule

// [sysclk_divider.sv]
// Divide-by-two stage and 8-bit reload prescaler for the system clock
`timescale 1ns/100ps
`include "clkpre_params.svh"
module sysclk_divider (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       x2_i,
  input  wire logic [7:0] reload_i,
  output logic            cpu_tick_o,
  output logic            sys_level_o,
  output logic            ovf_o
);
  import clkpre_pkg::*;
  div_state_t st_r;
  div_state_t st_nxt;
  logic       xt;
  logic       bypass;

  always_comb begin
    st_nxt = st_r;
    st_nxt.half = ~st_r.half;
    xt = x2_i | st_r.half;
    bypass = (reload_i == `RELOAD_BYPASS);
    st_nxt.tick = 1'b0;
    st_nxt.ovf = 1'b0;
    if (bypass) begin
      // Hold at FF so leaving bypass reloads on the next step
      st_nxt.cnt = 8'hFF;
      st_nxt.tick = xt;
      if (xt) begin
        st_nxt.lvl = ~st_r.lvl;
      end
    end else if (xt) begin
      if (st_r.cnt == 8'hFF) begin
        // FF->00 step takes one count, so load one past the value
        st_nxt.cnt = reload_i + 8'h01;
        st_nxt.ovf = 1'b1;
        st_nxt.lvl = ~st_r.lvl;
        st_nxt.tick = ~st_r.lvl;
      end else begin
        st_nxt.cnt = st_r.cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r <= '0;
      st_r.cnt <= 8'hFF;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign cpu_tick_o = st_r.tick;
  assign sys_level_o = st_r.lvl;
  assign ovf_o = st_r.ovf;

  a_bypass_rate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (reload_i == 8'hFF) && $stable(reload_i) && x2_i && $past(x2_i) |=> cpu_tick_o)
    else $error("bypass with double speed must tick every cycle");
  a_ovf_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ovf_o |-> st_r.cnt == $past(reload_i) + 8'h01)
    else $error("overflow did not reload the counter");
  a_level_toggle: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ovf_o |-> sys_level_o != $past(sys_level_o))
    else $error("overflow did not toggle the system clock");
endmodule

// [test_clock_prescaler.sv]
// Self-checking testbench for the clock prescaler block
`timescale 1ns/100ps
`include "clkpre_params.svh"
module test_clock_prescaler;
  import clkpre_pkg::*;
  logic          sys_clk_i;
  logic          reset_i;
  logic          fast_mode_i;
  logic          x2_default_i;
  reg_req_t      reg_req_i;
  logic [7:0]    reg_rdata_o;
  logic          cpu_tick_o;
  logic          sys_level_o;
  logic          x2_o;
  periph_ticks_t periph_ticks_o;
  logic [7:0]    tk;
  logic [3:0]    tl [3] = '{4'h0, 4'h5, 4'hF};
  int            fail_count;
  int            total_checks;
  int            p;

  assign tk = {periph_ticks_o, cpu_tick_o};

  clock_prescaler clock_prescaler_i (
    .sys_clk_i     (sys_clk_i),
    .reset_i       (reset_i),
    .reg_req_i     (reg_req_i),
    .reg_rdata_o   (reg_rdata_o),
    .fast_mode_i   (fast_mode_i),
    .x2_default_i  (x2_default_i),
    .cpu_tick_o    (cpu_tick_o),
    .sys_level_o   (sys_level_o),
    .x2_o          (x2_o),
    .periph_ticks_o(periph_ticks_o)
  );

  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic do_reset(input logic x2d);
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    x2_default_i <= x2d;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_i);
    reg_req_i <= '{addr: a, wdata: d, we: 1'b1, re: 1'b0};
    @(posedge sys_clk_i);
    reg_req_i.we <= 1'b0;
  endtask

  // Read data stands only in the cycle after the strobe
  task automatic rd_chk(input string what, input logic [7:0] a, input logic [7:0] exp);
    @(posedge sys_clk_i);
    reg_req_i <= '{addr: a, wdata: 8'h00, we: 1'b0, re: 1'b1};
    @(posedge sys_clk_i);
    reg_req_i.re <= 1'b0;
    #1 check(what, {8'h00, reg_rdata_o}, {8'h00, exp});
  endtask

  // Third interval only: the first two may straddle a reconfiguration
  task automatic measure(input int idx, output int per);
    int n;
    for (int k = 0; k < 3; k++) begin
      n = 0;
      do begin
        @(posedge sys_clk_i);
        #1 n++;
      end while (tk[idx] !== 1'b1 && n < 5000);
    end
    per = n;
  endtask

  function automatic int cpu_per(input logic [7:0] r, input logic x2);
    return (r == 8'hFF) ? (x2 ? 1 : 2) : 2 * (255 - int'(r)) * (x2 ? 1 : 2);
  endfunction

  function automatic int per_per(input int i, input logic fm, input logic b, input int timer_prescale_count,
                                 input int cp);
    logic [6:0] m;
    m = `PRESCALER_USERS;
    if (fm) return b ? cp * (timer_prescale_count + 1) : cp;
    return (m[i-1] ? cp * (timer_prescale_count + 1) : cp) * (b ? 2 : 1);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    reset_i = 1'b1;
    fast_mode_i = 1'b0;
    x2_default_i = 1'b0;
    reg_req_i = '0;
    fail_count = 0;
    total_checks = 0;
    do_reset(1'b0);
    rd_chk("reload reset", `RELOAD_ADDR, 8'hFF);
    rd_chk("prescale reset", `TPS_SETTING_ADDR, 8'h50);
    rd_chk("select reset", `PERIPH_SELECT_ADDR, 8'h00);
    check("x2 reset", {15'h0, x2_o}, 16'h0);
    measure(0, p);
    check("cpu bypass x1", p, cpu_per(8'hFF, 1'b0));
    wr(`PERIPH_SELECT_ADDR, 8'h01);
    measure(0, p);
    check("cpu bypass x2", p, cpu_per(8'hFF, 1'b1));
    wr(`RELOAD_ADDR, 8'hFE);
    measure(0, p);
    check("cpu ratio min", p, 2);
    rd_chk("reload readback", `RELOAD_ADDR, 8'hFE);
    wr(`PERIPH_SELECT_ADDR, 8'h00);
    wr(`RELOAD_ADDR, 8'h00);
    measure(0, p);
    check("cpu ratio max", p, 1020);
    // Slow rate left running: the new value must land within the bound
    wr(`RELOAD_ADDR, 8'hFC);
    repeat (1024) @(posedge sys_clk_i);
    measure(0, p);
    check("cpu after update", p, cpu_per(8'hFC, 1'b0));
    wr(8'h90, 8'h5A);
    rd_chk("unmapped", 8'h90, 8'h00);
    @(posedge sys_clk_i);
    #1 check("rdata idle", {8'h00, reg_rdata_o}, 16'h0);
    rd_chk("reload kept", `RELOAD_ADDR, 8'hFC);
    wr(`TPS_SETTING_ADDR, 8'hFF);
    rd_chk("prescale rw", `TPS_SETTING_ADDR, 8'hF0);
    wr(`PERIPH_SELECT_ADDR, 8'hAB);
    rd_chk("select rw", `PERIPH_SELECT_ADDR, 8'hAB);
    check("x2 bit", {15'h0, x2_o}, 16'h1);
    // Peripheral rates over both modes, both select states, edge prescales
    wr(`RELOAD_ADDR, 8'hFF);
    for (int fm = 0; fm < 2; fm++) begin
      for (int b = 0; b < 2; b++) begin
        foreach (tl[t]) begin
          @(posedge sys_clk_i);
          fast_mode_i <= fm[0];
          wr(`TPS_SETTING_ADDR, {tl[t], 4'h0});
          wr(`PERIPH_SELECT_ADDR, b[0] ? 8'hFE : 8'h00);
          for (int i = 1; i < 8; i++) begin
            measure(i, p);
            check("periph", p, per_per(i, fm[0], b[0], int'(tl[t]), 2));
          end
        end
      end
    end
    @(posedge sys_clk_i);
    fast_mode_i <= 1'b0;
    wr(`RELOAD_ADDR, 8'hFD);
    wr(`TPS_SETTING_ADDR, 8'h10);
    wr(`PERIPH_SELECT_ADDR, 8'h00);
    measure(0, p);
    check("cpu divided", p, cpu_per(8'hFD, 1'b0));
    measure(1, p);
    check("timer on divided", p, 2 * cpu_per(8'hFD, 1'b0));
    do_reset(1'b1);
    rd_chk("reload reset again", `RELOAD_ADDR, 8'hFF);
    rd_chk("select reset again", `PERIPH_SELECT_ADDR, 8'h01);
    check("x2 reset again", {15'h0, x2_o}, 16'h1);
    end_of_test();
  end

  initial begin
    #400000;
    fail_count++;
    end_of_test();
  end
endmodule

// [timer_prescaler.sv]
// Shared 4-bit down-counting timer prescaler
`timescale 1ns/100ps
`include "clkpre_params.svh"
module timer_prescaler (
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       cpu_tick_i,
  input  wire logic [3:0] tps_i,
  output logic            pre_tick_o
);
  import clkpre_pkg::*;
  tps_state_t st_r;
  tps_state_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    st_nxt.tick = 1'b0;
    if (cpu_tick_i) begin
      if (st_r.cnt == 4'h0) begin
        st_nxt.cnt = tps_i;
        st_nxt.tick = 1'b1;
      end else begin
        st_nxt.cnt = st_r.cnt - 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      st_r.cnt <= `TPS_RESET;
      st_r.tick <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pre_tick_o = st_r.tick;

  a_down_reload: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cpu_tick_i && st_r.cnt == 4'h0 |=> pre_tick_o && st_r.cnt == $past(tps_i))
    else $error("prescaler did not reload at zero");
  a_no_early_tick: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cpu_tick_i && st_r.cnt != 4'h0 |=> !pre_tick_o && st_r.cnt == $past(st_r.cnt) - 4'h1)
    else $error("prescaler ticked before reaching zero");
endmodule
